// ===== logic/spi_quirks.sv
// Serial peripheral controller with its documented deviations
`timescale 1ns/1ps
`include "spi_quirks_consts.svh"
module spi_quirks #(
   parameter int DEPTH = 8
) (
   input  wire logic                     clk,
   input  wire logic                     nrst,
   input  wire logic                     soft_reset,
   input  wire logic                     enable_cmd,
   input  wire logic                     disable_cmd,
   input  wire logic                     master_select_bit,
   input  wire logic                     fixed_mode,
   input  wire logic                     cs_hold_after_transfer,
   input  wire logic [7:0]               serial_clock_divider,
   input  wire logic                     cfg_write,
   input  wire logic                     cfg_write_cs0,
   input  wire logic [`BITS_W-1:0]       cfg_bits,
   input  wire logic                     tx_valid,
   output logic                          tx_ready,
   input  wire logic [`LAST_XFER_BIT:0]  transmit_data_register,
   output logic [1:0]                    dma_size,
   output logic                          enabled,
   output logic                          transmitter_empty_flag,
   output logic                          rx_valid,
   output logic [15:0]                   rx_data,
   input  wire logic                     rx_read,
   output logic                          serial_clock_pin,
   output logic                          mosi,
   input  wire logic                     miso,
   output logic                          cs_n
);
   typedef struct packed {
      spi_quirks_pkg::phase_t phase;
      spi_quirks_pkg::cfg_t   cfg;
      logic                   en;
      logic                   cfg_seen;
      logic [7:0]             divcnt;
      logic [4:0]             bitcnt;
      logic [15:0]            shreg;
      logic                   last;
      logic                   sck;
      logic                   extra;
      logic                   cs_n;
      logic                   stuck;
      logic [15:0]            rxd;
      logic                   rxv;
      logic [1:0]             miso_s;
   } top_state_t;
   top_state_t s, next_s;
   logic                     f_valid;
   logic                     f_pop;
   logic [`LAST_XFER_BIT:0]  f_data;
   logic                     f_in_ready;
   logic                     odd_quirk;

   // Words queue here so DMA can stream without waiting on the shifter
   spi_quirks_fifo #(.W(`LAST_XFER_BIT + 1), .D(DEPTH)) u_fifo (
      .clk       (clk),
      .nrst      (nrst),
      .in_valid  (tx_valid),
      .in_ready  (f_in_ready),
      .in_data   (transmit_data_register),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   assign tx_ready = f_in_ready & ~s.stuck;
   assign odd_quirk = (s.cfg.div == 8'h01) & s.cfg_seen & s.cfg.bits_sel[0];
   assign f_pop = s.en & s.cfg.master & f_valid & (s.phase != spi_quirks_pkg::ST_SHIFT) & ~s.stuck;
   assign dma_size = (s.cfg.fixed ? s.cfg.bits0 : s.cfg.bits_sel) > 5'h08 ? `DMA_HALF : `DMA_BYTE;
   assign enabled = s.en;
   assign transmitter_empty_flag = ~f_valid & (s.phase != spi_quirks_pkg::ST_SHIFT);
   assign rx_valid = s.rxv;
   assign rx_data = s.rxd;
   assign serial_clock_pin = s.sck;
   assign mosi = s.shreg[15];
   assign cs_n = s.cs_n;

   always_comb begin
      next_s = s;
      next_s.miso_s = {s.miso_s[0], miso};
      next_s.cfg.master = master_select_bit;
      next_s.cfg.fixed = fixed_mode;
      next_s.cfg.hold = cs_hold_after_transfer;
      next_s.cfg.div = serial_clock_divider;
      if (rx_read)
         next_s.rxv = 1'b0;
      if (enable_cmd)
         next_s.en = 1'b1;
      if (disable_cmd && s.cfg.master)
         next_s.en = 1'b0;
      if (cfg_write) begin
         next_s.cfg.bits_sel = cfg_bits;
         if (cfg_write_cs0)
            next_s.cfg.bits0 = cfg_bits;
         // Written before master select: the clock line starts toggling freely
         next_s.cfg_seen = 1'b1;
         if (!master_select_bit)
            next_s.extra = 1'b1;
      end
      if (s.extra && s.phase == spi_quirks_pkg::ST_IDLE && s.cfg.master)
         next_s.sck = ~s.sck;
      case (s.phase)
         spi_quirks_pkg::ST_IDLE, spi_quirks_pkg::ST_GAP: begin
            if (f_pop) begin
               next_s.extra = 1'b0;
               next_s.sck = 1'b0;
               next_s.phase = spi_quirks_pkg::ST_SHIFT;
               next_s.shreg = f_data[15:0] << (5'h10 - s.cfg.bits_sel);
               next_s.last = f_data[`LAST_XFER_BIT];
               next_s.bitcnt = s.cfg.bits_sel + {4'h0, odd_quirk};
               next_s.divcnt = s.cfg.div;
               next_s.cs_n = 1'b0;
               // Same slave after idle at full speed: ready stays low until a reset
               if (s.phase == spi_quirks_pkg::ST_GAP && s.cfg.hold && s.cfg.div == 8'h01)
                  next_s.stuck = 1'b1;
            end else if (s.phase == spi_quirks_pkg::ST_GAP && s.last && s.cfg.fixed && s.cfg.hold) begin
               next_s.cs_n = 1'b1;
               next_s.phase = spi_quirks_pkg::ST_IDLE;
            end else if (s.phase == spi_quirks_pkg::ST_GAP && !s.cfg.hold) begin
               next_s.cs_n = 1'b1;
               next_s.phase = spi_quirks_pkg::ST_IDLE;
            end
         end
         spi_quirks_pkg::ST_SHIFT: begin
            if (s.divcnt > 8'h01)
               next_s.divcnt = s.divcnt - 8'h01;
            else begin
               next_s.divcnt = s.cfg.div;
               next_s.sck = ~s.sck;
               if (s.sck) begin
                  next_s.shreg = {s.shreg[14:0], s.miso_s[1]};
                  next_s.bitcnt = s.bitcnt - 5'h01;
                  if (s.bitcnt == 5'h01) begin
                     next_s.phase = spi_quirks_pkg::ST_GAP;
                     next_s.rxd = {s.shreg[14:0], s.miso_s[1]};
                     next_s.rxv = 1'b1;
                  end
               end
            end
         end
         default: next_s.phase = spi_quirks_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s <= '0;
         s.cs_n <= 1'b1;
         s.cfg.bits0 <= `BITS_RESET;
         s.cfg.bits_sel <= `BITS_RESET;
         s.cfg.div <= `DIV_RESET;
      end else if (soft_reset) begin
         s <= '0;
         s.cs_n <= 1'b1;
         s.cfg.bits0 <= `BITS_RESET;
         s.cfg.bits_sel <= `BITS_RESET;
         s.cfg.div <= `DIV_RESET;
      end else
         s <= next_s;
   end

   AST_SLAVE_DISABLE: assert property (@(posedge clk) disable iff (!nrst)
      (s.en && !s.cfg.master && disable_cmd && !soft_reset) |=> s.en)
      else $error("Disable took effect in slave mode");
   AST_DMA_SIZE: assert property (@(posedge clk) disable iff (!nrst)
      (s.cfg.fixed && s.cfg.bits0 == 5'h0a) |-> dma_size == `DMA_HALF)
      else $error("Fixed mode size not from select 0");
   AST_STUCK: assert property (@(posedge clk) disable iff (!nrst)
      s.stuck |-> !tx_ready)
      else $error("Transmit ready rose while stuck");
   AST_LAST_CS: assert property (@(posedge clk) disable iff (!nrst || soft_reset)
      (s.phase == spi_quirks_pkg::ST_GAP && s.last && s.cfg.fixed && s.cfg.hold && !f_pop) |=> cs_n)
      else $error("Select not released after last transfer");
   AST_ODD: assert property (@(posedge clk) disable iff (!nrst || soft_reset)
      (f_pop && odd_quirk) |=> s.bitcnt == $past(s.cfg.bits_sel) + 5'h01)
      else $error("Missing extra clock pulse");
   AST_EARLY_SCK: assert property (@(posedge clk) disable iff (!nrst || soft_reset)
      (s.extra && s.phase == spi_quirks_pkg::ST_IDLE && s.cfg.master && !f_pop && !cfg_write)
      |=> serial_clock_pin != $past(serial_clock_pin))
      else $error("Early clock did not toggle");
   AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!nrst)
      soft_reset |=> (!s.en && cs_n && !rx_valid))
      else $error("Software reset left state");
   AST_CS_SHIFT: assert property (@(posedge clk) disable iff (!nrst)
      (s.phase == spi_quirks_pkg::ST_SHIFT) |-> !cs_n)
      else $error("Select high during shift");
endmodule // spi_quirks

// ===== logic/spi_quirks_consts.svh
// Constants of the quirky serial peripheral controller
// How it works
// - Hold plus divider 1, idle between same-slave words: transmit-ready stays low, no further word leaves the FIFO.
// - Fixed mode, hold, DMA: last-transfer flag at bit 24 releases select on transmitter empty.
// - Master mode: serial clock may toggle before first transfer if configured out of order.
// - Fixed mode DMA size always from chip select 0 word length; 10 bits means halfword.
// - Divider 1 with odd word length gives one extra serial clock pulse.
// - Disable command in slave mode has no effect.
`ifndef SPI_QUIRKS_CONSTS_SVH
`define SPI_QUIRKS_CONSTS_SVH
`define LAST_XFER_BIT   24
`define BITS_W          5
`define BITS_RESET      5'h08
`define DIV_RESET       8'h01
`define DMA_BYTE        2'h0
`define DMA_HALF        2'h1
`endif

// ===== logic/spi_quirks_fifo.sv
// Word FIFO between the transmit write port and the shifter
`timescale 1ns/1ps
module spi_quirks_fifo #(
   parameter int W = 25,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wr;
      logic [AW-1:0]       rd;
      logic [AW:0]         cnt;
   } fifo_state_t;
   fifo_state_t s, next_s;
   logic push, pop;
   assign in_ready  = (s.cnt != D[AW:0]);
   assign out_valid = (s.cnt != '0);
   assign out_data  = s.mem[s.rd];
   assign push = in_valid & in_ready;
   assign pop  = out_valid & out_ready;
   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (pop)
         next_s.rd = s.rd + 1'b1;
      next_s.cnt = s.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         s <= '0;
      else
         s <= next_s;
   end
endmodule // spi_quirks_fifo

// ===== logic/spi_quirks_pkg.sv
// Types of the quirky serial peripheral controller
package spi_quirks_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} phase_t;
   typedef struct packed {
      logic        hold;
      logic        fixed;
      logic        master;
      logic [7:0]  div;
      logic [4:0]  bits0;
      logic [4:0]  bits_sel;
   } cfg_t;
endpackage

// ===== tb/spi_quirks_bench.sv
// Self-checking bench for the quirky serial controller
`timescale 1ns/1ps
`include "spi_quirks_consts.svh"
module spi_quirks_bench;
   logic        clk, nrst, soft_reset, enable_cmd, disable_cmd, master_select_bit, fixed_mode;
   logic        cs_hold_after_transfer, cfg_write, cfg_write_cs0, tx_valid, tx_ready, rx_read;
   logic        enabled, transmitter_empty_flag, rx_valid, serial_clock_pin, mosi, miso, cs_n;
   logic [7:0]  serial_clock_divider;
   logic [4:0]  cfg_bits;
   logic [24:0] transmit_data_register;
   logic [1:0]  dma_size;
   logic [15:0] rx_data, got;
   int          fail_count, check_count, edges;

   spi_quirks #(.DEPTH(8)) dut_u (.clk(clk), .nrst(nrst), .soft_reset(soft_reset), .enable_cmd(enable_cmd),
      .disable_cmd(disable_cmd), .master_select_bit(master_select_bit), .fixed_mode(fixed_mode),
      .cs_hold_after_transfer(cs_hold_after_transfer), .serial_clock_divider(serial_clock_divider),
      .cfg_write(cfg_write), .cfg_write_cs0(cfg_write_cs0), .cfg_bits(cfg_bits), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .transmit_data_register(transmit_data_register), .dma_size(dma_size),
      .enabled(enabled), .transmitter_empty_flag(transmitter_empty_flag), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_read(rx_read), .serial_clock_pin(serial_clock_pin), .mosi(mosi),
      .miso(miso), .cs_n(cs_n));
   spi_slave_model slave_u (.serial_clock_pin(serial_clock_pin), .mosi(mosi), .cs_n(cs_n), .miso(miso),
      .got(got));

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task stop_test;
      if (fail_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Pulse order: rx_read, soft_reset, enable_cmd, disable_cmd
   task pulse(input logic [3:0] p);
      @(negedge clk) {rx_read, soft_reset, enable_cmd, disable_cmd} = p;
      @(negedge clk) {rx_read, soft_reset, enable_cmd, disable_cmd} = 4'h0;
   endtask
   task cfg(input logic [4:0] b, input logic both);
      @(negedge clk) {cfg_bits, cfg_write, cfg_write_cs0} = {b, 1'b1, both};
      @(negedge clk) {cfg_write, cfg_write_cs0} = 2'h0;
   endtask
   task send(input logic [24:0] w);
      @(negedge clk) {tx_valid, transmit_data_register} = {1'b1, w};
      while (tx_ready !== 1'b1) @(negedge clk);
      @(negedge clk) tx_valid = 1'b0;
   endtask
   task wait_empty;
      int n;
      n = 0;
      repeat (2) @(negedge clk);
      while (transmitter_empty_flag !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge serial_clock_pin) edges++;
   // Whole run is a few hundred cycles; this margin only cuts a hang
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      stop_test;
   end
   initial begin
      {nrst, rx_read, soft_reset, enable_cmd, disable_cmd, cfg_write, cfg_write_cs0, tx_valid} = 8'h00;
      {cs_hold_after_transfer, fixed_mode, master_select_bit} = 3'h3;
      {serial_clock_divider, cfg_bits, transmit_data_register} = {8'h02, 5'h08, 25'h0};
      {fail_count, check_count, edges} = 0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      cfg(5'h08, 1'b1);
      pulse(4'h2);
      edges = 0;
      send(25'h00000a5);
      wait_empty;
      chk(got, 16'h00a5);
      chk(16'(edges), 16'h0008);
      chk(rx_valid, 1'b1);
      chk(rx_data, 16'h00c3);
      pulse(4'h8);
      chk(rx_valid, 1'b0);
      cfg(5'h0a, 1'b1);
      cfg(5'h08, 1'b0);
      chk(dma_size, `DMA_HALF);
      cfg(5'h08, 1'b1);
      chk(dma_size, `DMA_BYTE);
      serial_clock_divider = 8'h01;
      for (int n = 8; n < 12; n++) begin
         cfg(5'(n), 1'b1);
         edges = 0;
         send(25'h0000155);
         wait_empty;
         chk(16'(edges), 16'(n + n % 2));
      end
      {serial_clock_divider, cs_hold_after_transfer} = {8'h02, 1'b1};
      cfg(5'h08, 1'b1);
      send(25'h000003c);
      wait_empty;
      chk(cs_n, 1'b0);
      send(25'h100003c);
      wait_empty;
      @(negedge clk);
      chk(cs_n, 1'b1);
      // Select cannot be kept low across such words; a held select must come from a general-purpose pin
      // Forbidden pairing set on purpose to expose the stuck ready
      serial_clock_divider = 8'h01;
      send(25'h0000081);
      wait_empty;
      repeat (4) @(negedge clk);
      send(25'h0000042);
      repeat (30) @(negedge clk);
      chk(tx_ready, 1'b0);
      {serial_clock_divider, cs_hold_after_transfer} = {8'h02, 1'b0};
      pulse(4'h4);
      chk(tx_ready, 1'b1);
      chk(enabled, 1'b0);
      repeat (8) send(25'h0000033);
      @(negedge clk);
      chk(tx_ready, 1'b0);
      pulse(4'h2);
      wait_empty;
      chk(tx_ready, 1'b1);
      pulse(4'h1);
      chk(enabled, 1'b0);
      master_select_bit = 1'b0;
      pulse(4'h2);
      pulse(4'h1);
      chk(enabled, 1'b1);
      pulse(4'h8);
      pulse(4'h4);
      chk(enabled, 1'b0);
      // Configuration written before master select: clock runs with no transfer queued
      master_select_bit = 1'b0;
      cfg(5'h08, 1'b1);
      master_select_bit = 1'b1;
      edges = 0;
      repeat (6) @(negedge clk);
      chk(16'(edges > 0), 16'h0001);
      stop_test;
   end
endmodule // spi_quirks_bench

// ===== tb/spi_slave_model.sv
// Behavioural serial slave that captures the data line and answers a fixed pattern
`timescale 1ns/1ps
module spi_slave_model #(
   parameter logic [15:0] REPLY = 16'hc35a
) (
   input  wire logic        serial_clock_pin,
   input  wire logic        mosi,
   input  wire logic        cs_n,
   output logic             miso,
   output logic [15:0]      got
);
   logic [15:0] out_sh = REPLY;
   // Select falls while the clock is low, so a low clock here marks a new frame
   always @(negedge cs_n or posedge serial_clock_pin) begin
      if (!serial_clock_pin)
         got = 16'h0000;
      else if (!cs_n)
         got = {got[14:0], mosi};
   end
   always @(posedge cs_n or negedge serial_clock_pin) begin
      if (cs_n)
         out_sh = REPLY;
      else
         out_sh = {out_sh[14:0], out_sh[15]};
   end
   // Released line shows the inverse, so a stale value is never mistaken for data
   assign miso = cs_n ? ~out_sh[15] : out_sh[15];
endmodule // spi_slave_model
